// [include/tsa_pkg.sv]
// Shared constants, register map and helpers of the time-slot assigner
package tsa_pkg;
  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_CHIP_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_TX_SLOT_CONTROL = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_RX_SLOT_CONTROL = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_CLOCK_EDGE_OFFSET = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_TX_SLOT_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_RX_SLOT_OFFSET = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_RX_BIT_MASK = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_TX_BIT_MASK = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_LINK_CONTROL = 4'h8;
  localparam logic [ADDR_W-1:0] IDX_LINK_STATUS = 4'h9;
  localparam logic [ADDR_W-1:0] IDX_RX_BYTE = 4'ha;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_HWY_EN = 7;
  localparam int CFG_SYNC_POL = 6;
  localparam int CFG_SYNC_EDGE = 5;
  localparam int TXC_OUT_A = 7;
  localparam int TXC_OUT_B = 6;
  localparam int RXC_IN_SEL = 7;
  localparam int SLOT_MSB = 5;
  localparam int SLOT_LSB = 0;
  localparam int CEO_TXBOF_MSB = 7;
  localparam int CEO_TXBOF_LSB = 5;
  localparam int CEO_TX_EDGE = 4;
  localparam int CEO_RXBOF_MSB = 3;
  localparam int CEO_RXBOF_LSB = 1;
  localparam int CEO_RX_EDGE = 0;
  localparam int OFS_ORDER = 6;
  localparam int CTL_TX_EN = 0;
  localparam int CTL_RX_ON = 1;
  localparam int CTL_STROBE = 2;
  localparam int STS_LOCK = 0;
  localparam int STS_ACTIVE = 1;
  localparam int STS_STARTED = 2;
  // ----------------------------------------------------------------
  // Reset values and fixed patterns
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] REG_RST = 8'h00;
  localparam logic [DATA_W-1:0] RX_MASK_RST = 8'hff;
  localparam logic [DATA_W-1:0] TX_MASK_RST = 8'h00;
  localparam logic [DATA_W-1:0] IDLE_BYTE = 8'hff;
  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int MIN_SLOTS = 3;
  localparam int MAX_SLOTS = 64;
  localparam int CNT_W = 10;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;

  function automatic logic [DATA_W-1:0] reverse8(input logic [DATA_W-1:0] b);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < DATA_W; i++) begin
      r[i] = b[DATA_W-1-i];
    end
    return r;
  endfunction
endpackage

// [rtl/tsa_sync.sv]
// Two-stage synchroniser for inputs from outside the mclk domain
`timescale 1ns/1ps
module tsa_sync #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      stage1_reg <= '0;
      synced <= '0;
    end else begin
      stage1_reg <= async;
      synced <= stage1_reg;
    end
  end
endmodule

// [rtl/tsa_slot_counter.sv]
// Frame bit counter and slot window for one direction
`timescale 1ns/1ps
module tsa_slot_counter #(
  parameter int CNT_W = tsa_pkg::CNT_W
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic syncPulse,
  input wire logic step,
  input wire logic [2:0] bitOffset,
  input wire logic [5:0] slotOffset,
  input wire logic [5:0] slotNumber,
  output logic hit,
  output logic [2:0] bitIdx,
  output logic [CNT_W-1:0] count
);
  logic [CNT_W-1:0] pos;
  logic [CNT_W-1:0] start;
  logic [CNT_W-1:0] delta;

  // Position of slot bit 0 relative to the frame start
  assign start = CNT_W'(bitOffset) + CNT_W'({slotOffset, 3'h0}) + CNT_W'({slotNumber, 3'h0});
  assign pos = syncPulse ? '0 : count;
  assign delta = pos - start;
  assign hit = (pos >= start) && (delta < CNT_W'(8));
  assign bitIdx = delta[2:0];

  always_ff @(posedge mclk) begin
    if (srst) begin
      count <= '0;
    end else if (step) begin
      // Saturate when sync goes missing
      count <= (&pos) ? pos : pos + CNT_W'(1);
    end else if (syncPulse) begin
      count <= '0;
    end
  end
endmodule

// [rtl/tsa_slot_assigner.sv]
// Time-slot assigner placing a serial stream into one TDM highway slot
// Behaviour
// (RULE1) Highway off: ignore sync, no slot gating
// (RULE2) Start in slot after sync, pin, unmasked bit
// (RULE3) First byte sent is always all ones
// (RULE4) Software disables outputs before changing slot parameters
// (RULE5) One frame needed to resynchronise after changes
// (RULE6) Sync pulse or reset restarts slot timing
// (RULE7) Supports three to sixty-four slots per frame
// (RULE8) Reset: receive mask ones, transmit mask zeros
// (RULE9) Sync polarity bit selects active level
// (RULE10) Partner sends sync within every 512 clocks
// (RULE11) Sync sampled on edge chosen by sample bit
// (RULE12) Transmit bit offset delays zero to seven bits
// (RULE13) Transmit start: bit + eight times slot sums
// (RULE14) Receive start: bit + eight times slot sums
// (RULE15) Transmit output floats outside slot and masked bits
// (RULE16) Strobe high outside slot and on masked bits
// (RULE17) Serial data goes least significant bit first
// (RULE18) Order bit clear reverses every transmitted byte
// (RULE19) Order bit clear reverses every received byte
// (RULE20) Order selects only act in highway mode
// (RULE21) Masks gate receive and transmit bits independently
// (RULE22) Edge selects pick launch and sample edges
// (RULE23) Output selects choose pins, both share data
// (RULE24) Mask bit per transmission position, count per edge
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module tsa_slot_assigner (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  input wire logic dataClk,
  input wire logic frameSync,
  input wire logic serialInA,
  input wire logic serialInB,
  output logic serialOutA,
  output logic serialOutAOeN,
  output logic serialOutB,
  output logic serialOutBOeN,
  input wire logic [7:0] txByte,
  output logic txLoad,
  output logic [7:0] rxByte,
  output logic [7:0] rxByteMask,
  output logic rxByteValid
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] chipConfig_reg, txSlotControl_reg, rxSlotControl_reg, clockEdgeOffset_reg;
  logic [7:0] txSlotOffset_reg, rxSlotOffset_reg, rxBitMask_reg, txBitMask_reg, linkControl_reg;
  logic frameLock_reg, txActive_reg, txStarted_reg, syncLevel_reg, dataClkPrev_reg;
  logic [7:0] txShift_reg, rxShift_reg, rxMaskAcc_reg;
  logic [2:0] freeTxIdx_reg, freeRxIdx_reg;

  logic highwayEnable, syncPolarity, syncSampleEdge, outASelect, outBSelect, rxInputSelect;
  logic txEdgeSelect, rxEdgeSelect, txOrderSelect, rxOrderSelect;
  logic transmitterEnable, receiverOn, strobeMode;
  assign highwayEnable = chipConfig_reg[tsa_pkg::CFG_HWY_EN];
  assign syncPolarity = chipConfig_reg[tsa_pkg::CFG_SYNC_POL];
  assign syncSampleEdge = chipConfig_reg[tsa_pkg::CFG_SYNC_EDGE];
  assign outASelect = txSlotControl_reg[tsa_pkg::TXC_OUT_A];
  assign outBSelect = txSlotControl_reg[tsa_pkg::TXC_OUT_B];
  assign rxInputSelect = rxSlotControl_reg[tsa_pkg::RXC_IN_SEL];
  assign txEdgeSelect = clockEdgeOffset_reg[tsa_pkg::CEO_TX_EDGE];
  assign rxEdgeSelect = clockEdgeOffset_reg[tsa_pkg::CEO_RX_EDGE];
  assign txOrderSelect = txSlotOffset_reg[tsa_pkg::OFS_ORDER];
  assign rxOrderSelect = rxSlotOffset_reg[tsa_pkg::OFS_ORDER];
  assign transmitterEnable = linkControl_reg[tsa_pkg::CTL_TX_EN];
  assign receiverOn = linkControl_reg[tsa_pkg::CTL_RX_ON];
  assign strobeMode = linkControl_reg[tsa_pkg::CTL_STROBE];

  always_ff @(posedge mclk) begin
    if (srst) begin
      chipConfig_reg <= tsa_pkg::REG_RST;
      txSlotControl_reg <= tsa_pkg::REG_RST;
      rxSlotControl_reg <= tsa_pkg::REG_RST;
      clockEdgeOffset_reg <= tsa_pkg::REG_RST;
      txSlotOffset_reg <= tsa_pkg::REG_RST;
      rxSlotOffset_reg <= tsa_pkg::REG_RST;
      rxBitMask_reg <= tsa_pkg::RX_MASK_RST; // [RULE8]
      txBitMask_reg <= tsa_pkg::TX_MASK_RST; // [RULE8]
      linkControl_reg <= tsa_pkg::REG_RST;
    end else if (wrStb) begin
      if (addr == tsa_pkg::IDX_CHIP_CONFIG) begin
        chipConfig_reg <= wrData;
      end else if (addr == tsa_pkg::IDX_TX_SLOT_CONTROL) begin
        txSlotControl_reg <= wrData;
      end else if (addr == tsa_pkg::IDX_RX_SLOT_CONTROL) begin
        rxSlotControl_reg <= wrData;
      end else if (addr == tsa_pkg::IDX_CLOCK_EDGE_OFFSET) begin
        clockEdgeOffset_reg <= wrData;
      end else if (addr == tsa_pkg::IDX_TX_SLOT_OFFSET) begin
        txSlotOffset_reg <= wrData;
      end else if (addr == tsa_pkg::IDX_RX_SLOT_OFFSET) begin
        rxSlotOffset_reg <= wrData;
      end else if (addr == tsa_pkg::IDX_RX_BIT_MASK) begin
        rxBitMask_reg <= wrData;
      end else if (addr == tsa_pkg::IDX_TX_BIT_MASK) begin
        txBitMask_reg <= wrData;
      end else if (addr == tsa_pkg::IDX_LINK_CONTROL) begin
        linkControl_reg <= wrData;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst || !rdStb) begin
      rdData <= tsa_pkg::REG_RST;
    end else if (addr == tsa_pkg::IDX_CHIP_CONFIG) begin
      rdData <= chipConfig_reg;
    end else if (addr == tsa_pkg::IDX_TX_SLOT_CONTROL) begin
      rdData <= txSlotControl_reg;
    end else if (addr == tsa_pkg::IDX_RX_SLOT_CONTROL) begin
      rdData <= rxSlotControl_reg;
    end else if (addr == tsa_pkg::IDX_CLOCK_EDGE_OFFSET) begin
      rdData <= clockEdgeOffset_reg;
    end else if (addr == tsa_pkg::IDX_TX_SLOT_OFFSET) begin
      rdData <= txSlotOffset_reg;
    end else if (addr == tsa_pkg::IDX_RX_SLOT_OFFSET) begin
      rdData <= rxSlotOffset_reg;
    end else if (addr == tsa_pkg::IDX_RX_BIT_MASK) begin
      rdData <= rxBitMask_reg;
    end else if (addr == tsa_pkg::IDX_TX_BIT_MASK) begin
      rdData <= txBitMask_reg;
    end else if (addr == tsa_pkg::IDX_LINK_CONTROL) begin
      rdData <= linkControl_reg;
    end else if (addr == tsa_pkg::IDX_LINK_STATUS) begin
      rdData <= {5'h00, txStarted_reg, txActive_reg, frameLock_reg};
    end else if (addr == tsa_pkg::IDX_RX_BYTE) begin
      rdData <= rxByte;
    end else begin
      rdData <= tsa_pkg::REG_RST;
    end
  end

  // ----------------------------------------------------------------
  // Pin sampling and edge detection
  // ----------------------------------------------------------------
  logic [3:0] pinSync;
  logic dataClkS, frameSyncS, serialInAS, serialInBS;
  tsa_sync #(.W(4)) uPinSync (
    .mclk(mclk),
    .srst(srst),
    .async({dataClk, frameSync, serialInA, serialInB}),
    .synced(pinSync)
  );
  assign {dataClkS, frameSyncS, serialInAS, serialInBS} = pinSync;

  logic clkRise, clkFall, txEdge, rxEdge, syncEdge, syncAsserted, syncPulse;
  assign clkRise = dataClkS && !dataClkPrev_reg;
  assign clkFall = !dataClkS && dataClkPrev_reg;
  assign txEdge = txEdgeSelect ? clkRise : clkFall; // [RULE22]
  assign rxEdge = rxEdgeSelect ? clkRise : clkFall; // [RULE22]
  assign syncEdge = syncSampleEdge ? clkRise : clkFall; // [RULE11]
  assign syncAsserted = (frameSyncS == syncPolarity); // [RULE9]
  // Leading edge of a valid sync, only in highway mode
  assign syncPulse = highwayEnable && syncEdge && syncAsserted && !syncLevel_reg; // [RULE1] [RULE6]

  always_ff @(posedge mclk) begin
    if (srst) begin
      dataClkPrev_reg <= 1'b0;
      syncLevel_reg <= 1'b0;
    end else begin
      dataClkPrev_reg <= dataClkS;
      if (syncEdge) begin
        syncLevel_reg <= syncAsserted;
      end
    end
  end

  // Timing only trusted after a sync seen in highway mode
  always_ff @(posedge mclk) begin
    if (srst || !highwayEnable) begin
      frameLock_reg <= 1'b0;
    end else if (syncPulse) begin
      frameLock_reg <= 1'b1; // [RULE5]
    end
  end

  // ----------------------------------------------------------------
  // Slot counters, up to 64 slots of 8 bits
  // ----------------------------------------------------------------
  logic txHit, rxHit;
  logic [2:0] txIdx, rxIdx;
  logic [tsa_pkg::CNT_W-1:0] txCount, rxCount;
  tsa_slot_counter #(.CNT_W(tsa_pkg::CNT_W)) uTxCounter ( // [RULE7] [RULE24]
    .mclk(mclk),
    .srst(srst),
    .syncPulse(syncPulse),
    .step(txEdge),
    .bitOffset(clockEdgeOffset_reg[tsa_pkg::CEO_TXBOF_MSB:tsa_pkg::CEO_TXBOF_LSB]), // [RULE12] [RULE13]
    .slotOffset(txSlotOffset_reg[tsa_pkg::SLOT_MSB:tsa_pkg::SLOT_LSB]),
    .slotNumber(txSlotControl_reg[tsa_pkg::SLOT_MSB:tsa_pkg::SLOT_LSB]),
    .hit(txHit),
    .bitIdx(txIdx),
    .count(txCount)
  );
  tsa_slot_counter #(.CNT_W(tsa_pkg::CNT_W)) uRxCounter ( // [RULE7] [RULE24]
    .mclk(mclk),
    .srst(srst),
    .syncPulse(syncPulse),
    .step(rxEdge),
    .bitOffset(clockEdgeOffset_reg[tsa_pkg::CEO_RXBOF_MSB:tsa_pkg::CEO_RXBOF_LSB]), // [RULE14]
    .slotOffset(rxSlotOffset_reg[tsa_pkg::SLOT_MSB:tsa_pkg::SLOT_LSB]),
    .slotNumber(rxSlotControl_reg[tsa_pkg::SLOT_MSB:tsa_pkg::SLOT_LSB]),
    .hit(rxHit),
    .bitIdx(rxIdx),
    .count(rxCount)
  );

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  logic anyPin, txSlotStart, txFirst, txBitMasked, txWindow, freeLoad;
  logic [7:0] txUser, txLoadByte, txCur;
  logic [2:0] txPos;
  assign anyPin = outASelect || (outBSelect && !strobeMode);
  assign txWindow = highwayEnable && frameLock_reg && txHit;
  assign txSlotStart = txEdge && txWindow && (txIdx == tsa_pkg::FIRST_BIT);
  assign txFirst = txSlotStart && !txStarted_reg && anyPin && (txBitMask_reg != 8'h00); // [RULE2]
  assign freeLoad = txEdge && !highwayEnable && (freeTxIdx_reg == tsa_pkg::FIRST_BIT);
  assign txUser = transmitterEnable ? txByte : tsa_pkg::IDLE_BYTE;
  assign txLoadByte = (txFirst || !txStarted_reg) ? tsa_pkg::IDLE_BYTE : txUser; // [RULE3]
  // Reverse only in highway mode with order bit clear
  always_comb begin
    txCur = txShift_reg;
    if (txSlotStart || freeLoad) begin
      txCur = (highwayEnable && !txOrderSelect) ? tsa_pkg::reverse8(txLoadByte) : txLoadByte; // [RULE18] [RULE20]
    end
  end
  assign txPos = highwayEnable ? txIdx : freeTxIdx_reg;
  assign txBitMasked = !txBitMask_reg[txIdx]; // [RULE21] [RULE24]

  always_ff @(posedge mclk) begin
    if (srst || !highwayEnable || !anyPin) begin
      txActive_reg <= 1'b0;
      txStarted_reg <= 1'b0;
    end else if (txFirst) begin
      txActive_reg <= 1'b1; // [RULE2]
      txStarted_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      txShift_reg <= tsa_pkg::IDLE_BYTE;
      freeTxIdx_reg <= tsa_pkg::FIRST_BIT;
      txLoad <= 1'b0;
    end else begin
      txShift_reg <= txCur;
      txLoad <= transmitterEnable && (freeLoad || (txSlotStart && txActive_reg && txStarted_reg));
      if (txEdge && !highwayEnable) begin
        freeTxIdx_reg <= freeTxIdx_reg + 3'h1;
      end
    end
  end

  // Pin drive, updated on launch edges only
  logic txDrive, txBit;
  assign txBit = txCur[txPos]; // [RULE17]
  // First bit of the first slot drives before txActive_reg is set
  assign txDrive = highwayEnable ? (txWindow && (txActive_reg || txFirst) && !txBitMasked) : transmitterEnable; // [RULE2] [RULE15]
  always_ff @(posedge mclk) begin
    if (srst) begin
      serialOutA <= 1'b1;
      serialOutAOeN <= 1'b1;
      serialOutB <= 1'b1;
      serialOutBOeN <= 1'b1;
    end else if (txEdge) begin
      serialOutA <= txBit;
      serialOutAOeN <= !(txDrive && outASelect); // [RULE23]
      if (strobeMode) begin
        serialOutBOeN <= 1'b0;
        serialOutB <= highwayEnable ? !(outASelect && txWindow && !txBitMasked) : !outASelect; // [RULE16]
      end else begin
        serialOutB <= txBit;
        serialOutBOeN <= !(txDrive && outBSelect); // [RULE23]
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  logic rxIn, rxTake, rxLast;
  logic [2:0] rxPos;
  logic [7:0] rxMaskUse;
  assign rxIn = rxInputSelect ? serialInBS : serialInAS;
  assign rxPos = highwayEnable ? rxIdx : freeRxIdx_reg;
  assign rxMaskUse = highwayEnable ? rxBitMask_reg : tsa_pkg::RX_MASK_RST;
  assign rxTake = rxEdge && receiverOn && (!highwayEnable || (frameLock_reg && rxHit));
  assign rxLast = rxTake && (rxPos == tsa_pkg::LAST_BIT);

  always_ff @(posedge mclk) begin
    if (srst) begin
      rxShift_reg <= 8'h00;
      rxMaskAcc_reg <= 8'h00;
      freeRxIdx_reg <= tsa_pkg::FIRST_BIT;
    end else if (rxTake) begin
      if (rxMaskUse[rxPos]) begin
        rxShift_reg[rxPos] <= rxIn; // [RULE21]
      end
      rxMaskAcc_reg[rxPos] <= rxMaskUse[rxPos];
      freeRxIdx_reg <= freeRxIdx_reg + 3'h1;
    end
  end

  logic [7:0] rxDone, rxDoneMask;
  always_comb begin
    rxDone = rxShift_reg;
    rxDoneMask = rxMaskAcc_reg;
    rxDone[rxPos] = rxMaskUse[rxPos] ? rxIn : rxShift_reg[rxPos];
    rxDoneMask[rxPos] = rxMaskUse[rxPos];
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rxByte <= 8'h00;
      rxByteMask <= 8'h00;
      rxByteValid <= 1'b0;
    end else begin
      rxByteValid <= rxLast;
      if (rxLast) begin
        rxByte <= (highwayEnable && !rxOrderSelect) ? tsa_pkg::reverse8(rxDone) : rxDone; // [RULE19] [RULE20]
        rxByteMask <= (highwayEnable && !rxOrderSelect) ? tsa_pkg::reverse8(rxDoneMask) : rxDoneMask;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_sync_ignored;
    !highwayEnable |=> !frameLock_reg && !txActive_reg;
  endproperty
  a_sync_ignored: assert property (p_sync_ignored) else $error("sync acted on while highway off"); // [RULE1]

  property p_mask_reset;
    $past(srst) |-> rxBitMask_reg == 8'hff && txBitMask_reg == 8'h00;
  endproperty
  a_mask_reset: assert property (@(posedge mclk) p_mask_reset) else $error("mask reset values wrong"); // [RULE8]

  property p_first_byte;
    txFirst |=> txShift_reg == 8'hff && txStarted_reg;
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("first byte not all ones"); // [RULE3]

  property p_start_needs_pin;
    $rose(txActive_reg) |-> $past(anyPin) && $past(txBitMask_reg) != 8'h00 && $past(frameLock_reg);
  endproperty
  a_start_needs_pin: assert property (p_start_needs_pin) else $error("transmit started without pin or mask"); // [RULE2]

  property p_float_masked;
    txEdge && highwayEnable && !(txHit && !txBitMasked) |=> serialOutAOeN;
  endproperty
  a_float_masked: assert property (p_float_masked) else $error("pin A driven outside owned bit"); // [RULE15]

  property p_strobe_high;
    txEdge && strobeMode && highwayEnable && !(txWindow && !txBitMasked) |=> serialOutB && !serialOutBOeN;
  endproperty
  a_strobe_high: assert property (p_strobe_high) else $error("strobe low outside slot"); // [RULE16]

  property p_sync_restart;
    syncPulse && !txEdge |=> txCount == '0;
  endproperty
  a_sync_restart: assert property (p_sync_restart) else $error("counter not restarted by sync"); // [RULE6]

  property p_tx_reverse;
    txSlotStart && txActive_reg && txStarted_reg && transmitterEnable && !txOrderSelect
      |=> txShift_reg == tsa_pkg::reverse8($past(txByte));
  endproperty
  a_tx_reverse: assert property (p_tx_reverse) else $error("transmit byte not reversed"); // [RULE18]

  sequence s_rx_pulse;
    rxByteValid ##1 !rxByteValid;
  endsequence
  property p_rx_byte;
    rxLast |=> s_rx_pulse;
  endproperty
  a_rx_byte: assert property (p_rx_byte) else $error("receive byte pulse malformed"); // [RULE14]

  property p_both_pins;
    txEdge && outASelect && outBSelect && !strobeMode |=> serialOutA == serialOutB && serialOutAOeN == serialOutBOeN;
  endproperty
  a_both_pins: assert property (p_both_pins) else $error("broadcast pins differ"); // [RULE23]
endmodule

// [bench/tsa_hwy_model.sv]
// TDM highway partner: free-running data clock, frame sync, receive data
`timescale 1ns/1ps
module tsa_hwy_model (
  output logic dataClk,
  output logic frameSync,
  output logic serialInA,
  output logic serialInB,
  output logic [4:0] bitNo,
  input wire logic [31:0] pattern
);
  initial begin
    dataClk = 1'b0;
    bitNo = 5'h1f;
    frameSync = 1'b0;
    serialInA = 1'b1;
    serialInB = 1'b0;
  end
  always #80 dataClk = ~dataClk;
  // Sync high in the last bit of each 32-bit frame
  always @(posedge dataClk) begin
    bitNo <= bitNo + 5'h1;
    frameSync <= (bitNo == 5'h1e);
    serialInA <= pattern[bitNo+5'h1];
    serialInB <= ~pattern[bitNo+5'h1];
  end
endmodule

// [bench/testbench.sv]
// Self-checking bench of the time-slot assigner
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0, srst = 1'b1, wrStb = 1'b0, rdStb = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wrData = 8'h00, txByte = 8'h35, rdData, rxByte, rxByteMask, capByte, lastByte;
  logic dataClk, frameSync, serialInA, serialInB, serialOutA, serialOutAOeN, serialOutB, serialOutBOeN;
  logic txLoad, rxByteValid;
  logic [4:0] bitNo, capFirst, lastFirst;
  int miscompares = 0, compares = 0, cycles = 0, capCnt = 0, lastCnt, stbCnt = 0, lastStb, bDrv = 0;
  int ldCnt = 0, rvCnt = 0, ld0, rv0;
  tsa_hwy_model u_tsa_hwy_model (.dataClk(dataClk), .frameSync(frameSync), .serialInA(serialInA),
    .serialInB(serialInB), .bitNo(bitNo), .pattern(32'h0060_8000));
  tsa_slot_assigner u_tsa_slot_assigner (.mclk(mclk), .srst(srst), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .dataClk(dataClk), .frameSync(frameSync),
    .serialInA(serialInA), .serialInB(serialInB), .serialOutA(serialOutA), .serialOutAOeN(serialOutAOeN),
    .serialOutB(serialOutB), .serialOutBOeN(serialOutBOeN), .txByte(txByte), .txLoad(txLoad),
    .rxByte(rxByte), .rxByteMask(rxByteMask), .rxByteValid(rxByteValid));
  always #5 mclk = ~mclk;
  // Mid-bit capture of what the block drives, stored per frame
  always @(negedge dataClk) begin
    if (bitNo == 5'h0) begin
      lastByte = capByte;
      lastCnt = capCnt;
      lastFirst = capFirst;
      lastStb = stbCnt;
      capCnt = 0;
      stbCnt = 0;
    end
    if (serialOutAOeN === 1'b0) begin
      if (capCnt == 0) capFirst = bitNo;
      capByte = {serialOutA, capByte[7:1]};
      capCnt++;
    end
    if (serialOutBOeN === 1'b0 && serialOutB === 1'b0) stbCnt++;
    if (serialOutBOeN === 1'b0) bDrv++;
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    #1;
    chk($sformatf("reg%h", a), exp, rdData);
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge dataClk);
      #1;
      while (bitNo !== 5'h0) begin
        @(posedge dataClk);
        #1;
      end
    end
    @(negedge dataClk);
    #1;
  endtask
  task automatic complete_run;
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (txLoad === 1'b1) ldCnt++;
    if (rxByteValid === 1'b1) rvCnt++;
    if (cycles == 30000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 12; i++) rd(i[3:0], (i == 6) ? 8'hff : 8'h00);
    wr(tsa_pkg::IDX_LINK_CONTROL, 8'h03);
    wr(tsa_pkg::IDX_TX_SLOT_CONTROL, 8'h01);
    wr(tsa_pkg::IDX_CLOCK_EDGE_OFFSET, 8'h70);
    wr(tsa_pkg::IDX_TX_SLOT_OFFSET, 8'h40);
    wr(tsa_pkg::IDX_RX_SLOT_CONTROL, 8'h02);
    wr(tsa_pkg::IDX_RX_SLOT_OFFSET, 8'h40);
    wr(tsa_pkg::IDX_TX_BIT_MASK, 8'hff);
    rd(tsa_pkg::IDX_CLOCK_EDGE_OFFSET, 8'h70);
    frames(2);
    rd(tsa_pkg::IDX_LINK_STATUS, 8'h00);
    wr(tsa_pkg::IDX_CHIP_CONFIG, 8'hc0);
    frames(2);
    rd(tsa_pkg::IDX_LINK_STATUS, 8'h01);
    for (int k = 0; k < 2; k++) begin
      wr(tsa_pkg::IDX_LINK_CONTROL, 8'h02);
      wr(tsa_pkg::IDX_TX_SLOT_CONTROL, 8'h01);
      wr(tsa_pkg::IDX_TX_SLOT_OFFSET, k ? 8'h00 : 8'h40);
      frames(1);
      wr(tsa_pkg::IDX_TX_SLOT_CONTROL, 8'h81);
      wr(tsa_pkg::IDX_LINK_CONTROL, 8'h03);
      frames(1);
      chk("firstByte", 8'hff, lastByte);
      chk("firstPos", 8'd11, {3'h0, lastFirst});
      ld0 = ldCnt;
      frames(1);
      chk("dataByte", k ? 8'hac : 8'h35, lastByte);
      chk("bitCount", 8'd8, lastCnt[7:0]);
      chk("loadPulses", 8'd1, 8'(ldCnt - ld0));
    end
    chk("pinBDriven", 8'd0, bDrv[7:0]);
    chk("rxByteLsb", 8'hc1, rxByte);
    wr(tsa_pkg::IDX_RX_SLOT_OFFSET, 8'h00);
    wr(tsa_pkg::IDX_TX_BIT_MASK, 8'h0f);
    wr(tsa_pkg::IDX_RX_BIT_MASK, 8'h0f);
    wr(tsa_pkg::IDX_LINK_CONTROL, 8'h07);
    rv0 = rvCnt;
    frames(3);
    chk("rxByteRev", 8'h83, rxByte);
    chk("rxByteMask", 8'hf0, rxByteMask);
    chk("rxPulses", 8'd3, 8'(rvCnt - rv0));
    chk("maskedCount", 8'd4, lastCnt[7:0]);
    chk("strobeCount", 8'd4, lastStb[7:0]);
    complete_run();
  end
endmodule
